// File: logic/asr_pkg.sv
// Package: constants for the asynchronous byte-wide static memory host controller
`default_nettype none
package asr_pkg;
  // ----------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------
  localparam int ADDR_W = 17;
  localparam int DATA_W = 8;
  localparam int DEPTH = 131072;
  // ----------------------------------------------------------------
  // Clock and timing (ns, as printed, slowest grade by default)
  // ----------------------------------------------------------------
  localparam int CLK_NS = 4;
  localparam int T_CR_NS = 150;      // Read cycle / address access
  localparam int T_AOE_NS = 75;      // Drive gate access
  localparam int T_DIS_NS = 45;      // Output float after strobe release
  localparam int T_EN_NS = 10;       // Earliest memory drive
  localparam int T_WP_NS = 90;       // Address / chip pick set-up to write end
  localparam int T_SUD_NS = 50;      // Data set-up before write end
  localparam int T_PDR_NS = 150;     // Power-down recovery, one read cycle
  // Least times round up to whole cycles
  function automatic int ns2cyc(input int ns);
    int c;
    c = (ns + CLK_NS - 1) / CLK_NS;
    return (c < 1) ? 1 : c;
  endfunction
  localparam int RD_CYC = ns2cyc(T_CR_NS);
  localparam int WR_CYC = ns2cyc(T_WP_NS);
  localparam int FLOAT_CYC = ns2cyc(T_DIS_NS);
  localparam int PDR_CYC = ns2cyc(T_PDR_NS);
  localparam int CNT_W = 8;
  // ----------------------------------------------------------------
  // Sequencer states (one-bit steps only idle-setup, setup-read, write-release, power-down-recover)
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ASR_IDLE = 3'h0,
    ASR_SETUP = 3'h1,
    ASR_RD = 3'h3,
    ASR_WR = 3'h2,
    ASR_REL = 3'h6,
    ASR_PD = 3'h7,
    ASR_RECOV = 3'h5
  } asr_state_e;
endpackage
`default_nettype wire

// File: logic/asr_tmr.sv
// Down counter that raises done when a loaded cycle count has elapsed
`timescale 1ns/100ps
`default_nettype none
module asr_tmr #(
  parameter int W = 8
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic load,
  input wire logic [W-1:0] count,
  output logic done
);
  logic [W-1:0] cnt_q;
  // ----------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (srst) begin
      cnt_q <= '0;
    end else if (load) begin
      cnt_q <= count;
    end else if (cnt_q != '0) begin
      cnt_q <= cnt_q - 1'b1;
    end
  end
  // Done while the count sits at zero; load is left out so that a caller
  // that loads on done does not form a combinational loop
  assign done = (cnt_q == '0);
endmodule // asr_tmr
`default_nettype wire

// File: logic/asr_host.sv
// Host controller driving an asynchronous 128K x 8 static memory
`timescale 1ns/100ps
`default_nettype none
module asr_host
  import asr_pkg::*;
#(
  parameter int RD_CYCLES = asr_pkg::RD_CYC,
  parameter int WR_CYCLES = asr_pkg::WR_CYC,
  parameter int FLOAT_CYCLES = asr_pkg::FLOAT_CYC,
  parameter int PDR_CYCLES = asr_pkg::PDR_CYC
) (
  input wire logic mclk,
  input wire logic srst,
  // User side
  input wire logic req_valid,
  output logic req_ready,
  input wire logic req_write,
  input wire logic [asr_pkg::ADDR_W-1:0] req_addr,
  input wire logic [asr_pkg::DATA_W-1:0] req_wdata,
  output logic rsp_valid,
  output logic [asr_pkg::DATA_W-1:0] rsp_rdata,
  input wire logic pd_req,
  output logic pd_active,
  // Memory side
  output logic [asr_pkg::ADDR_W-1:0] mem_addr,
  output logic chip_pick_n,
  output logic store_n,
  output logic drive_gate_n,
  input wire logic [asr_pkg::DATA_W-1:0] dq_i,
  output logic [asr_pkg::DATA_W-1:0] dq_o,
  output logic dq_oe
);
  import asr_pkg::*;

  asr_state_e state_q;
  logic write_q;
  logic tmr_load;
  logic [CNT_W-1:0] tmr_count;
  logic tmr_done;

  // ----------------------------------------------------------------
  // Interval timer
  // ----------------------------------------------------------------
  asr_tmr #(.W(CNT_W)) u_tmr (
    .mclk(mclk),
    .srst(srst),
    .load(tmr_load),
    .count(tmr_count),
    .done(tmr_done)
  );

  // Timer loads on entry to each timed state; done comes from the count alone,
  // so loading on done here never loops back through the timer
  always_comb begin
    tmr_load = 1'b0;
    tmr_count = '0;
    case (state_q)
      ASR_IDLE: begin
        if (pd_req) begin
          tmr_load = 1'b0;
        end else if (req_valid) begin
          tmr_load = 1'b1;
          tmr_count = CNT_W'(1);
        end
      end
      ASR_SETUP: begin
        if (tmr_done) begin
          tmr_load = 1'b1;
          tmr_count = write_q ? CNT_W'(WR_CYCLES) : CNT_W'(RD_CYCLES);
        end
      end
      ASR_RD, ASR_WR: begin
        if (tmr_done) begin
          tmr_load = 1'b1;
          tmr_count = CNT_W'(FLOAT_CYCLES);
        end
      end
      ASR_PD: begin
        if (!pd_req) begin
          tmr_load = 1'b1;
          tmr_count = CNT_W'(PDR_CYCLES);
        end
      end
      default: begin
        tmr_load = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (srst) begin
      state_q <= ASR_IDLE;
    end else begin
      case (state_q)
        ASR_IDLE: begin
          if (pd_req) begin
            state_q <= ASR_PD;  // Chip pick already high
          end else if (req_valid) begin
            state_q <= ASR_SETUP;
          end
        end
        ASR_SETUP: begin
          if (tmr_done) begin
            state_q <= write_q ? ASR_WR : ASR_RD;
          end
        end
        ASR_RD: begin
          if (tmr_done) begin
            state_q <= ASR_REL;
          end
        end
        ASR_WR: begin
          if (tmr_done) begin
            state_q <= ASR_REL;
          end
        end
        ASR_REL: begin
          if (tmr_done) begin
            state_q <= ASR_IDLE;  // Memory has floated
          end
        end
        ASR_PD: begin
          if (!pd_req) begin
            state_q <= ASR_RECOV;
          end
        end
        ASR_RECOV: begin
          if (tmr_done) begin
            state_q <= ASR_IDLE;  // Wait one read cycle
          end
        end
        default: begin
          state_q <= ASR_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Request capture: address and data held for the whole access
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (srst) begin
      write_q <= 1'b0;
      mem_addr <= '0;
      dq_o <= '0;
    end else if (state_q == ASR_IDLE && req_valid && !pd_req) begin
      write_q <= req_write;
      mem_addr <= req_addr;  // Stable through the strobe
      dq_o <= req_wdata;
    end
  end

  // ----------------------------------------------------------------
  // Strobes, registered so they never glitch
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (srst) begin
      chip_pick_n <= 1'b1;
      store_n <= 1'b1;
      drive_gate_n <= 1'b1;
      dq_oe <= 1'b0;
    end else begin
      // Chip pick low only while an access runs
      chip_pick_n <= !((state_q == ASR_SETUP && tmr_done) || state_q == ASR_RD
                       || (state_q == ASR_WR && !tmr_done));
      // Store falls with chip pick so memory never drives
      store_n <= !((state_q == ASR_SETUP && tmr_done && write_q)
                   || (state_q == ASR_WR && !tmr_done));
      // Store and chip pick rise on one edge, data held on the bus
      // Drive gate only on reads
      drive_gate_n <= !((state_q == ASR_SETUP && tmr_done && !write_q)
                        || (state_q == ASR_RD && !tmr_done));
      // Host drives only in a write, memory outputs forced off
      dq_oe <= (state_q == ASR_SETUP && tmr_done && write_q)
               || (state_q == ASR_WR && !tmr_done)
               || (state_q == ASR_WR && tmr_done);
    end
  end

  // ----------------------------------------------------------------
  // Read data capture at the end of the access window
  // ----------------------------------------------------------------
  // The answer is a one-cycle pulse; the byte stays until the next read
  always_ff @(posedge mclk) begin
    if (srst) begin
      rsp_valid <= 1'b0;
      rsp_rdata <= '0;
    end else begin
      rsp_valid <= 1'b0;
      if (state_q == ASR_RD && tmr_done) begin
        rsp_valid <= 1'b1;
        rsp_rdata <= dq_i;  // Sampled after full access time
      end
    end
  end

  // Request handshake decoded from the state and masked by pd_req; power-down status decoded from the state
  assign req_ready = (state_q == ASR_IDLE) && !pd_req;
  assign pd_active = (state_q == ASR_PD);
endmodule // asr_host
`default_nettype wire

// File: tb/asr_host_assertions.sv
// Checker for the memory-side pins of the static memory host controller
`timescale 1ns/100ps
`default_nettype none
module asr_host_assertions
  import asr_pkg::*;
#(
  parameter int WR_CYCLES = 4,
  parameter int PDR_CYCLES = 4
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic rsp_valid,
  input wire logic pd_active,
  input wire logic [asr_pkg::ADDR_W-1:0] mem_addr,
  input wire logic chip_pick_n,
  input wire logic store_n,
  input wire logic drive_gate_n,
  input wire logic dq_oe
);
  logic [7:0] low_q;
  logic [7:0] rec_q;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);
  // Cycles chip pick held low, and cycles since power-down ended
  always_ff @(posedge mclk) begin
    low_q <= chip_pick_n ? 8'h00 : low_q + 8'h01;
    rec_q <= srst ? 8'hff : pd_active ? 8'h00 : (rec_q == 8'hff) ? rec_q : rec_q + 8'h01;
  end
  property p_fight; dq_oe |-> drive_gate_n; endproperty
  a_fight: assert property (p_fight) else $error("host drives during read");
  property p_addr; (!store_n && !$fell(store_n)) |-> $stable(mem_addr); endproperty
  a_addr: assert property (p_addr) else $error("address moved in write");
  property p_cs; $rose(store_n) |-> low_q >= WR_CYCLES; endproperty
  a_cs: assert property (p_cs) else $error("chip pick low too short");
  property p_pd; pd_active |-> chip_pick_n; endproperty
  a_pd: assert property (p_pd) else $error("chip pick low in power-down");
  property p_rec; $fell(chip_pick_n) |-> rec_q >= PDR_CYCLES; endproperty
  a_rec: assert property (p_rec) else $error("access too soon after power-down");
  property p_ovl; !drive_gate_n |-> store_n; endproperty
  a_ovl: assert property (p_ovl) else $error("drive gate and store overlap");
  property p_st; $fell(store_n) |-> $fell(chip_pick_n); endproperty
  a_st: assert property (p_st) else $error("store not with chip pick");
  property p_ans; $rose(drive_gate_n) |-> ##[0:2] rsp_valid; endproperty
  a_ans: assert property (p_ans) else $error("read not answered");
endmodule // asr_host_assertions
bind asr_host asr_host_assertions #(.WR_CYCLES(WR_CYCLES), .PDR_CYCLES(PDR_CYCLES)) u_chk (
  .mclk(mclk), .srst(srst), .rsp_valid(rsp_valid), .pd_active(pd_active),
  .mem_addr(mem_addr), .chip_pick_n(chip_pick_n), .store_n(store_n),
  .drive_gate_n(drive_gate_n), .dq_oe(dq_oe));
`default_nettype wire

// File: tb/asr_sram_model.sv
// Behavioural model of the asynchronous byte-wide static memory
`timescale 1ns/100ps
`default_nettype none
module asr_sram_model
  import asr_pkg::*;
(
  input wire logic [asr_pkg::ADDR_W-1:0] addr,
  input wire logic cs_n,
  input wire logic we_n,
  input wire logic oe_n,
  input wire logic host_oe,
  input wire logic [asr_pkg::DATA_W-1:0] host_d,
  output logic [asr_pkg::DATA_W-1:0] dq
);
  logic [DATA_W-1:0] mem [DEPTH];
  logic [DATA_W-1:0] last = 8'h00;
  wire rd = !cs_n && we_n && !oe_n;
  wire wr = !cs_n && !we_n;
  wire rd_late;
  // Output stage turns on 10 ns late, off at once
  assign #(T_EN_NS) rd_late = rd;
  // Store on the end of the overlap
  always @(negedge wr) mem[addr] = host_d;
  always @(negedge rd) last = mem[addr];
  // Released bus shows the inverse of the last byte
  assign dq = host_oe ? host_d : (rd && rd_late) ? mem[addr] : ~last;
endmodule // asr_sram_model
`default_nettype wire

// File: tb/tb_top.sv
// Testbench for the static memory host controller
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import asr_pkg::*;
  localparam int PDR = 4;
  logic mclk = 1'h0;
  logic srst = 1'h1;
  logic req_valid = 1'h0;
  logic req_write = 1'h0;
  logic pd_req = 1'h0;
  logic [ADDR_W-1:0] req_addr = 17'h0;
  logic [DATA_W-1:0] req_wdata = 8'h0;
  logic req_ready, rsp_valid, pd_active, chip_pick_n, store_n, drive_gate_n, dq_oe;
  logic [ADDR_W-1:0] mem_addr;
  logic [DATA_W-1:0] rsp_rdata, dq_i, dq_o;
  logic [ADDR_W-1:0] at [3] = '{17'h00000, 17'h1ffff, 17'h0a5a5};
  logic [DATA_W-1:0] dt [3] = '{8'h3c, 8'hc3, 8'h5a};
  int failures = 0;
  int comparisons = 0;
  always #2 mclk = ~mclk;
  asr_host #(.RD_CYCLES(4), .WR_CYCLES(4), .FLOAT_CYCLES(2), .PDR_CYCLES(PDR)) asr_host_inst (
    .mclk(mclk), .srst(srst), .req_valid(req_valid), .req_ready(req_ready),
    .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata), .rsp_valid(rsp_valid),
    .rsp_rdata(rsp_rdata), .pd_req(pd_req), .pd_active(pd_active), .mem_addr(mem_addr),
    .chip_pick_n(chip_pick_n), .store_n(store_n), .drive_gate_n(drive_gate_n),
    .dq_i(dq_i), .dq_o(dq_o), .dq_oe(dq_oe));
  asr_sram_model asr_sram_model_inst (.addr(mem_addr), .cs_n(chip_pick_n), .we_n(store_n),
    .oe_n(drive_gate_n), .host_oe(dq_oe), .host_d(dq_o), .dq(dq_i));
  // Count one mismatch and print it
  task fail(input string m);
    failures++;
    $display("wrong value t=%0t %s", $time, m);
  endtask
  task end_sim;
    $display("failures=%0d comparisons=%0d", failures, comparisons);
    if (failures == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Hold a request until taken, then release it
  task automatic req(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    int n = 0;
    req_valid <= 1'h1;
    req_write <= w;
    req_addr <= a;
    req_wdata <= d;
    do begin
      @(posedge mclk);
      n++;
    end while (req_ready !== 1'h1 && n < 100);
    req_valid <= 1'h0;
    @(posedge mclk);
    if (n >= 100) begin
      fail("request not taken");
      end_sim;
    end
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    int n = 0;
    req(1'h0, a, 8'h00);
    while (rsp_valid !== 1'h1 && n < 100) begin
      @(posedge mclk);
      n++;
    end
    if (n >= 100) begin
      fail("read not answered");
      end_sim;
    end
    comparisons++;
    if (rsp_rdata !== e) fail("read data");
  endtask
  // Scenarios
  task t_idle;
    comparisons++;
    if (chip_pick_n !== 1'h1 || store_n !== 1'h1) fail("idle strobes");
    comparisons++;
    if (drive_gate_n !== 1'h1 || dq_oe !== 1'h0) fail("idle drive");
    comparisons++;
    if (req_ready !== 1'h1 || rsp_valid !== 1'h0 || mem_addr !== 17'h0) fail("reset");
  endtask
  task t_wr_rd;
    for (int i = 0; i < 3; i++) req(1'h1, at[i], dt[i]);
    for (int i = 0; i < 3; i++) rd(at[i], dt[i]);
    req(1'h1, at[0], 8'hff);
    rd(at[0], 8'hff);
  endtask
  task automatic t_pd;
    int n = 0;
    pd_req <= 1'h1;
    while (pd_active !== 1'h1 && n < 100) begin
      @(posedge mclk);
      n++;
    end
    repeat (2) @(posedge mclk);
    comparisons++;
    if (n >= 100 || pd_active !== 1'h1 || req_ready !== 1'h0) fail("power-down");
    comparisons++;
    if (chip_pick_n !== 1'h1 || dq_oe !== 1'h0) fail("chip pick in power-down");
    if (n >= 100) end_sim;
    n = 0;
    pd_req <= 1'h0;
    do begin
      @(posedge mclk);
      n++;
    end while (req_ready !== 1'h1 && n < 100);
    comparisons++;
    if (n < PDR || n >= 100) fail("recovery wait");
    if (n >= 100) end_sim;
    rd(at[1], dt[1]);
  endtask
  initial begin
    repeat (8) @(posedge mclk);
    srst <= 1'h0;
    @(posedge mclk);
    t_idle;
    t_wr_rd;
    t_pd;
    end_sim;
  end
endmodule // tb_top
`default_nettype wire
